// ### hw/mcs_top.sv
// Microcode store read path: stores, strobe timing, microword register, bus slave
//
// What this block does
// - Below 16K basic store, 16K-20K user store.
// - Basic store 16K x 24, one-bit arrays.
// - Seven shared address lines, row then column.
// - Row from bits 13:11,03:00; column 10:04.
// - Address bit 14 suppresses column strobe.
// - User store four 1K banks, decoded select.
// - No bank select unless user store addressed.
// - Parallel-load mode loads all 24 bits.
// - Otherwise shift serial in; taps 7,15,23.
// - Microcycle of phases 0-2, one 270 ns microstate.
// - Stall withholds phase 2 and register clock.
// - Local-store write pulse from T225 to T270.
// - Microword stays put for the whole microcycle.
// - Row select, row strobe, column select, column strobe.
// - User store addressed directly after bank select.
// - Strobes derived from clock and phases 0,1.
// - Write gate low suppresses column strobe.
// - Refresh suppresses row select, column select and column strobe; row strobe and bank select still run.
// - Microword bus carries read and write data.
// - One-row refresh every 12.8 us from counter.
// - Refresh row counter steps after each refresh.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mcs_top (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [mcs_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [mcs_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic [mcs_pkg::NA_W-1:0]  next_addr_lines,
    input  wire logic                      stall_in,
    output logic [mcs_pkg::RA_W-1:0]       store_addr_lines,
    output logic                           row_select_level,
    output logic                           col_select_level,
    output logic                           row_strobe,
    output logic                           col_strobe,
    output logic [mcs_pkg::BANKS-1:0]      user_bank_select,
    output logic                           store_write_gate,
    output logic                           refresh_active,
    output logic [mcs_pkg::RA_W-1:0]       refresh_row_counter,
    output logic [mcs_pkg::MW_W-1:0]       microword_register,
    output logic [2:0]                     diag_taps,
    output logic                           microword_reg_clock,
    output logic                           local_store_write_pulse
);
    import mcs_pkg::*;

    logic [2:0]        cnt_r;
    logic [2:0]        cnt_nxt;
    logic              ms_end;
    logic              hold_r;
    logic              hold_c;
    logic [3:0]        ctrl_r;
    logic [MW_W-1:0]   wdata_r;
    logic              step_pend_r;
    mcs_wr_e           wst_r;
    mcs_wr_e           wst_nxt;
    logic              gate_nxt;
    logic              wr_drive_r;
    logic              refr_pend_r;
    logic [REFR_W-1:0] refr_tmr_r;
    logic [RA_W-1:0]   row_lat_r;
    logic              bs_acc;
    logic              us_acc;
    logic [MW_W-1:0]   bs_q;
    logic [MW_W-1:0]   us_q_r;
    logic              bs_drv_r;
    logic              us_drv_r;
    logic [MW_W-1:0]   mw_bus;
    logic [MW_W-1:0]   user_mem [0:USER_WDS-1];
    logic              is_basic;
    logic              is_user;
    logic              aw_got_r;
    logic              w_got_r;
    logic [7:0]        aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              wr_fire;
    logic [31:0]       rd_mux;
    logic              rd_hit;
    logic              wr_hit;

    // Microstate position; one microstate is MS_CYC clocks
    assign ms_end  = (cnt_r == MS_LAST);
    assign cnt_nxt = ms_end ? 3'h0 : 3'(cnt_r + 3'h1);
    always_ff @(posedge aclk) begin
        if (!aresetn) cnt_r <= 3'h0;
        else          cnt_r <= cnt_nxt;
    end

    // Address decode between the two stores
    assign is_basic = !next_addr_lines[NA_USER];
    assign is_user  = next_addr_lines[NA_USER] && (next_addr_lines[13:12] == 2'h0);

    // Phase-2 hold: external stall, refresh microstate, maintenance stop
    assign hold_c = stall_in || refresh_active ||
                    (ctrl_r[CTL_MAINT] && !step_pend_r);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_r                  <= 1'b1;
            local_store_write_pulse <= 1'b0;
        end else begin
            if (cnt_r == HOLD_C) hold_r <= hold_c;
            local_store_write_pulse <= (cnt_r == HOLD_C) && !hold_c;
        end
    end

    // Phase-2 clock: loads or shifts the microword, held during stalls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            microword_register  <= '0;
            microword_reg_clock <= 1'b0;
        end else begin
            microword_reg_clock <= ms_end && !hold_r;
            if (ms_end && !hold_r) begin
                if (ctrl_r[CTL_PL])
                    microword_register <= mw_bus;
                else
                    microword_register <= {microword_register[MW_W-2:0],
                                           ctrl_r[CTL_SIN]};
            end
        end
    end
    assign diag_taps = {microword_register[23], microword_register[15],
                        microword_register[7]};

    // Store write sequence: gate low, drive, write interval, gate low, release
    always_comb begin
        wst_nxt = wst_r;
        if (ms_end) begin
            case (wst_r)
                W_IDLE:  wst_nxt = ctrl_r[CTL_WREQ] ? W_PRE : W_IDLE;
                W_PRE:   wst_nxt = W_ACT;
                W_ACT:   wst_nxt = ctrl_r[CTL_WREQ] ? W_ACT : W_POST;
                W_POST:  wst_nxt = W_IDLE;
                default: wst_nxt = W_IDLE;
            endcase
        end
    end
    assign gate_nxt = (wst_nxt != W_PRE) && (wst_nxt != W_POST);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r            <= W_IDLE;
            store_write_gate <= 1'b1;
            wr_drive_r       <= 1'b0;
        end else begin
            wst_r            <= wst_nxt;
            store_write_gate <= gate_nxt;
            wr_drive_r       <= (wst_nxt == W_ACT) || (wst_nxt == W_POST);
        end
    end

    // Refresh timer, pending request and row counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refr_tmr_r          <= '0;
            refr_pend_r         <= 1'b0;
            refresh_active      <= 1'b0;
            refresh_row_counter <= '0;
        end else begin
            refr_tmr_r <= (refr_tmr_r == REFR_LAST) ? '0 : REFR_W'(refr_tmr_r + 1'b1);
            if (ms_end) begin
                refresh_active <= refr_pend_r;
                if (refresh_active)
                    refresh_row_counter <= RA_W'(refresh_row_counter + 1'b1);
            end
            if (refr_tmr_r == REFR_LAST) refr_pend_r <= 1'b1;
            else if (ms_end)             refr_pend_r <= 1'b0;
        end
    end

    // Strobe timing circuit, outputs registered from the next position
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store_addr_lines <= '0;
            row_select_level <= 1'b0;
            col_select_level <= 1'b0;
            row_strobe       <= 1'b0;
            col_strobe       <= 1'b0;
            user_bank_select <= '0;
        end else begin
            if (ms_end ? refr_pend_r : refresh_active)
                store_addr_lines <= refresh_row_counter;
            else if (cnt_nxt >= COL_SEL_C)
                store_addr_lines <= next_addr_lines[10:4];
            else
                store_addr_lines <= {next_addr_lines[13:11], next_addr_lines[3:0]};
            row_select_level <= !(ms_end ? refr_pend_r : refresh_active) &&
                                (cnt_nxt >= ROW_SEL_C) && (cnt_nxt < COL_SEL_C);
            row_strobe       <= (cnt_nxt >= RAS_C);
            col_select_level <= !(ms_end ? refr_pend_r : refresh_active) &&
                                (cnt_nxt >= COL_SEL_C);
            col_strobe       <= !(ms_end ? refr_pend_r : refresh_active) &&
                                is_basic && gate_nxt && (cnt_nxt >= CAS_C);
            if (is_user && gate_nxt && (cnt_nxt >= BANK_C))
                user_bank_select <= BANKS'(4'h1 << next_addr_lines[11:10]);
            else
                user_bank_select <= '0;
        end
    end

    // Array accesses at position CAS_C, under column strobe or bank select
    assign bs_acc = col_strobe && (cnt_r == CAS_C);
    assign us_acc = (user_bank_select != '0) && (cnt_r == CAS_C);
    always_ff @(posedge aclk) begin
        if (!aresetn) row_lat_r <= '0;
        else if (cnt_r == RAS_C) row_lat_r <= store_addr_lines;
    end

    // Basic store: one single-bit array per microword bit
    for (genvar b = 0; b < MW_W; b++) begin : g_bit
        logic bit_mem [0:BASIC_WDS-1];
        logic bit_q_r;
        always_ff @(posedge aclk) begin
            if (bs_acc) begin
                if (wr_drive_r) bit_mem[{row_lat_r, store_addr_lines}] <= wdata_r[b];
                else            bit_q_r <= bit_mem[{row_lat_r, store_addr_lines}];
            end
        end
        assign bs_q[b] = bit_q_r;
    end

    // User store: bank select plus direct location bits
    always_ff @(posedge aclk) begin
        if (us_acc) begin
            if (wr_drive_r) user_mem[next_addr_lines[11:0]] <= wdata_r;
            else            us_q_r <= user_mem[next_addr_lines[11:0]];
        end
    end

    // Bus drivers; arrays drive only on a read, released at the load edge
    always_ff @(posedge aclk) begin
        if (!aresetn || ms_end) begin
            bs_drv_r <= 1'b0;
            us_drv_r <= 1'b0;
        end else begin
            if (bs_acc && !wr_drive_r) bs_drv_r <= 1'b1;
            if (us_acc && !wr_drive_r) us_drv_r <= 1'b1;
        end
    end
    always_comb begin
        if (wr_drive_r)    mw_bus = wdata_r;
        else if (bs_drv_r) mw_bus = bs_q;
        else if (us_drv_r) mw_bus = us_q_r;
        else               mw_bus = '0;
    end

    // Bus slave write channels: address and data in either order
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_hit  = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_STEP) ||
                     (aw_addr_r == REG_WDATA) || (aw_addr_r == REG_MWORD) ||
                     (aw_addr_r == REG_STATUS);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= '0;
            w_strb_r      <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= {s_axi_awaddr[7:2], 2'h0};
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register effects of a write; a step request wins over its own clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r      <= CTRL_RST;
            wdata_r     <= '0;
            step_pend_r <= 1'b0;
        end else begin
            if (ms_end && !hold_r) step_pend_r <= 1'b0;
            if (wr_fire && w_strb_r[0]) begin
                if (aw_addr_r == REG_CTRL) ctrl_r <= w_data_r[3:0];
                if (aw_addr_r == REG_STEP) step_pend_r <= 1'b1;
            end
            if (wr_fire && (aw_addr_r == REG_WDATA)) begin
                for (int i = 0; i < 3; i++) begin
                    if (w_strb_r[i]) wdata_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
                end
            end
        end
    end

    // Bus slave read channel
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        case ({s_axi_araddr[7:2], 2'h0})
            REG_CTRL:   rd_mux[3:0]     = ctrl_r;
            REG_STEP:   rd_mux[0]       = step_pend_r;
            REG_WDATA:  rd_mux[MW_W-1:0] = wdata_r;
            REG_MWORD:  rd_mux[MW_W-1:0] = microword_register;
            REG_STATUS: begin
                rd_mux[RA_W-1:0]         = refresh_row_counter;
                rd_mux[ST_RACT]          = refresh_active;
                rd_mux[ST_GATE]          = store_write_gate;
                rd_mux[ST_TAPS +: 3]     = diag_taps;
            end
            default:    rd_hit          = 1'b0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks on strobe order, store selection, bus ownership and clocking
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    strobe_order_a: assert property ($rose(col_strobe) |-> row_strobe &&
        $past(row_select_level, 2)) else $error("column strobe before row");
    basic_desel_a: assert property ($rose(col_strobe) |->
        !$past(next_addr_lines[14])) else $error("column strobe for user store");
    bank_gate_a: assert property ((user_bank_select != '0) |->
        $past(next_addr_lines[14]) && $onehot(user_bank_select))
        else $error("bank select without user address");
    refresh_quiet_a: assert property (refresh_active && cnt_r != 3'h0 |->
        !col_strobe && !row_select_level && !col_select_level)
        else $error("timing output during refresh");
    write_gate_a: assert property (!store_write_gate |-> !col_strobe)
        else $error("column strobe while write gate low");
    bus_owner_a: assert property (!(bs_drv_r && us_drv_r) &&
        !(wr_drive_r && (bs_drv_r || us_drv_r))) else $error("bus contention");
    par_load_a: assert property (microword_reg_clock && $past(ctrl_r[CTL_PL]) |->
        microword_register == $past(mw_bus)) else $error("parallel load wrong");
    shift_load_a: assert property (microword_reg_clock && !$past(ctrl_r[CTL_PL]) |->
        microword_register == {$past(microword_register[MW_W-2:0]),
        $past(ctrl_r[CTL_SIN])}) else $error("shift load wrong");
    ls_pulse_a: assert property (local_store_write_pulse |->
        ##1 microword_reg_clock) else $error("write pulse without clock");
    refr_stall_a: assert property ($fell(refresh_active) |->
        !microword_reg_clock && $past(refresh_row_counter) + 7'h1 == refresh_row_counter)
        else $error("refresh microstate clocked or counter stuck");
    word_hold_a: assert property (!microword_reg_clock |->
        $stable(microword_register)) else $error("microword changed mid cycle");
endmodule : mcs_top

// ### hw/mcs_pkg.sv
// Constants, register map and state types of the microcode store read path
package mcs_pkg;
    // Clock and microstate timing
    localparam int       CLK_NS    = 40;
    localparam int       MS_NS     = 270;
    localparam int       MS_CYC    = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int       LSW_NS    = 225;
    localparam int       REFR_NS   = 12800;
    localparam int       REFR_CYC  = REFR_NS / CLK_NS;
    localparam int       REFR_W    = 9;
    localparam logic [2:0] MS_LAST   = 3'(MS_CYC - 1);
    localparam logic [2:0] ROW_SEL_C = 3'h1;
    localparam logic [2:0] RAS_C     = 3'h2;
    localparam logic [2:0] COL_SEL_C = 3'h3;
    localparam logic [2:0] CAS_C     = 3'h4;
    localparam logic [2:0] BANK_C    = 3'h1;
    localparam logic [2:0] LSW_C     = 3'((LSW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] HOLD_C    = 3'(LSW_C - 3'h1);
    localparam logic [REFR_W-1:0] REFR_LAST = REFR_W'(REFR_CYC - 1);
    // Store geometry
    localparam int       NA_W      = 15;
    localparam int       MW_W      = 24;
    localparam int       RA_W      = 7;
    localparam int       BANKS     = 4;
    localparam int       BASIC_WDS = 16384;
    localparam int       USER_WDS  = 4096;
    localparam int       NA_USER   = 14;
    // Register bus
    localparam int       AXI_AW    = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STEP   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_MWORD  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int       CTL_PL    = 0;
    localparam int       CTL_SIN   = 1;
    localparam int       CTL_MAINT = 2;
    localparam int       CTL_WREQ  = 3;
    localparam logic [3:0] CTRL_RST  = 4'h1;
    localparam int       ST_RACT   = 8;
    localparam int       ST_GATE   = 9;
    localparam int       ST_TAPS   = 10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Store write sequence
    typedef enum logic [3:0] {
        W_IDLE = 4'h1,
        W_PRE  = 4'h2,
        W_ACT  = 4'h4,
        W_POST = 4'h8
    } mcs_wr_e;
endpackage : mcs_pkg

// ### sim/mcs_seq_model.sv
// Sequencer model: presents the next microaddress after each microword load
`timescale 1ns/1ps
module mcs_seq_model (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     microword_reg_clock,
    input  wire logic [mcs_pkg::NA_W-1:0] addr_req,
    output logic [mcs_pkg::NA_W-1:0]      next_addr_lines
);
    import mcs_pkg::*;
    // New address follows each load and then stands for the whole microstate
    always_ff @(posedge aclk) begin
        if (!aresetn || microword_reg_clock) begin
            next_addr_lines <= addr_req;
        end
    end
endmodule : mcs_seq_model

// ### sim/mcs_top_bench.sv
// Self-checking bench of the microcode store read path
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mcs_top_bench;
    import mcs_pkg::*;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]        s_axi_wstrb, user_bank_select;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready, stall_in, row_select_level, col_select_level, row_strobe;
    logic              col_strobe, store_write_gate, refresh_active, mon_on, rs_q, ra_q, lsw_q;
    logic              microword_reg_clock, local_store_write_pulse;
    logic [NA_W-1:0]   next_addr_lines, addr_req, na_q;
    logic [RA_W-1:0]   store_addr_lines, refresh_row_counter, rc_q;
    logic [MW_W-1:0]   microword_register, mw_q;
    logic [2:0]        diag_taps;
    int                fail_count, check_count, gap, rgap, nref, i, k;

    mcs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .next_addr_lines, .stall_in, .store_addr_lines, .row_select_level,
        .col_select_level, .row_strobe, .col_strobe, .user_bank_select, .store_write_gate,
        .refresh_active, .refresh_row_counter, .microword_register, .diag_taps,
        .microword_reg_clock, .local_store_write_pulse);
    mcs_seq_model u_seq (.aclk, .aresetn, .microword_reg_clock, .addr_req, .next_addr_lines);

    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // A wait that used up its bound ends the run
    task automatic tmo(input int n);
        if (n >= 60) begin
            fail_count++;
            report_and_stop();
        end
    endtask : tmo

    // Bus write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        tmo(n);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        @(posedge aclk); // Ready is lowered for one edge before the next request
    endtask : axw

    // Bus read: result left in rd
    task automatic axr(input logic [7:0] a, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        tmo(n);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er)
        @(posedge aclk); // Ready is lowered for one edge before the next request
    endtask : axr

    // Wait for a number of microword loads
    task automatic loads(input int m);
        int n;
        repeat (m) begin
            for (n = 0; n < 60; n++) begin
                @(posedge aclk);
                if (microword_reg_clock) break;
            end
            tmo(n);
        end
    endtask : loads

    // Store write under stall: the address already stands on the lines, so no loads occur
    task automatic wr(input logic [14:0] a, input logic [23:0] d);
        addr_req <= a;
        axw(REG_WDATA, {8'h00, d}, RESP_OKAY);
        axw(REG_CTRL, 32'h9, RESP_OKAY);
        repeat (4 * MS_CYC) @(posedge aclk);
        axw(REG_CTRL, 32'h1, RESP_OKAY);
        repeat (3 * MS_CYC) @(posedge aclk);
    endtask : wr

    // Port monitor: strobe order, addresses, selects, load timing, refresh
    always @(posedge aclk) begin
        if (mon_on) begin
            if (row_strobe && !rs_q && !refresh_active)
                `CHK(store_addr_lines, {next_addr_lines[13:11], next_addr_lines[3:0]})
            if (col_strobe) `CHK({row_strobe, col_select_level, next_addr_lines[14]}, 3'h6)
            if (col_strobe) `CHK(store_addr_lines, next_addr_lines[10:4])
            if (|user_bank_select) `CHK(user_bank_select, 4'h1 << na_q[11:10])
            if (|user_bank_select) `CHK(na_q[14:12], 3'h4)
            if (microword_register !== mw_q) `CHK(microword_reg_clock, 1'b1)
            if (microword_reg_clock) `CHK(gap % 7, 0)
            if (microword_reg_clock) `CHK(lsw_q, 1'b1)
        end
        if (refresh_active && row_strobe) `CHK(store_addr_lines, refresh_row_counter)
        if (refresh_active) `CHK({col_strobe, row_select_level, col_select_level}, 3'h0)
        if (!store_write_gate) `CHK(col_strobe, 1'b0)
        if (refresh_active && !ra_q && nref > 0) `CHK(refresh_row_counter, rc_q + 7'h1)
        if (refresh_active && !ra_q && nref > 0) `CHK(rgap > 312 && rgap < 328, 1'b1)
        if (refresh_active && !ra_q) begin
            rc_q <= refresh_row_counter;
            nref <= nref + 1;
            rgap <= 1;
        end else rgap <= rgap + 1;
        gap <= microword_reg_clock ? 1 : gap + 1;
        rs_q <= row_strobe;
        ra_q <= refresh_active;
        lsw_q <= local_store_write_pulse;
        mw_q <= microword_register;
        na_q <= next_addr_lines; // Selects are registered from the previous address
    end

    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mon_on, nref} = '0;
        stall_in = 1'b1; // Nothing is loaded before the stores hold data
        s_axi_wstrb = 4'hF;
        addr_req = 15'h2A5C;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(REG_CTRL, RESP_OKAY);
        `CHK(rd[3:0], CTRL_RST)
        axr(REG_STATUS, RESP_OKAY);
        `CHK(rd[ST_GATE], 1'b1)
        axr(8'h20, RESP_SLVERR);
        axw(8'h24, 32'h0, RESP_SLVERR);
        axw(REG_MWORD, 32'h0, RESP_OKAY);
        // Each store is written while stalled; one load moves the address on
        wr(15'h2A5C, 24'hA5C3E1);
        addr_req <= 15'h4D23;
        stall_in <= 1'b0;
        loads(1);
        stall_in <= 1'b1;
        mon_on <= 1'b1;
        `CHK(microword_register, 24'hA5C3E1)
        wr(15'h4D23, 24'h5A3C1E);
        stall_in <= 1'b0;
        loads(1);
        `CHK(microword_register, 24'h5A3C1E)
        addr_req <= 15'h2A5C;
        loads(2);
        `CHK(microword_register, 24'hA5C3E1)
        addr_req <= 15'h4D23;
        loads(2);
        `CHK(microword_register, 24'h5A3C1E)
        // Shift eight ones in with the machine stopped before load mode is dropped
        mon_on <= 1'b0;
        axw(REG_CTRL, 32'h5, RESP_OKAY);
        repeat (2 * MS_CYC) @(posedge aclk);
        axw(REG_CTRL, 32'h6, RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            axw(REG_STEP, 32'h1, RESP_OKAY);
            k = 0;
            do begin
                axr(REG_STEP, RESP_OKAY);
                k++;
            end while (rd[0] && k < 20);
            tmo(k * 3);
        end
        axr(REG_MWORD, RESP_OKAY);
        `CHK(rd[23:0], 24'h3C1EFF)
        `CHK(diag_taps, 3'h1)
        axw(REG_CTRL, 32'h1, RESP_OKAY);
        loads(1);
        mon_on <= 1'b1;
        // Stall holds phase 2 for whole microstates
        stall_in <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            `CHK(microword_reg_clock, 1'b0)
        end
        stall_in <= 1'b0;
        loads(1);
        repeat (700) @(posedge aclk);
        `CHK(nref > 2, 1'b1)
        report_and_stop();
    end
endmodule : mcs_top_bench
